// ---- src/ixs_pkg.sv ----
// Shared constants, opcodes and carriers for the instruction-subset execution block
package ixs_pkg;
   // Register map (byte addresses, AXI4-Lite word aligned)
   localparam logic [7:0] ADDR_ACC = 8'h00;
   localparam logic [7:0] ADDR_FLAGS = 8'h04;
   localparam logic [7:0] ADDR_PTR_LO = 8'h08;
   localparam logic [7:0] ADDR_PTR_HI = 8'h0C;
   localparam logic [7:0] ADDR_LATCH_HI = 8'h10;
   localparam logic [7:0] ADDR_CMD = 8'h14;
   localparam logic [7:0] ADDR_STATUS = 8'h18;
   localparam logic [7:0] ADDR_MEM_ADDR = 8'h1C;
   localparam logic [7:0] ADDR_MEM_DATA = 8'h20;
   localparam logic [7:0] ADDR_PROG_ADDR = 8'h24;
   localparam logic [7:0] ADDR_PROG_DATA = 8'h28;
   // Flag register bit positions
   localparam int FLAG_C = 0;
   localparam int FLAG_NIBBLE = 1;
   localparam int FLAG_Z = 2;
   localparam int FLAG_WRAP = 3;
   localparam int FLAG_SIGN = 4;
   localparam int FLAG_W = 5;
   // Command register fields
   localparam int CMD_OP_LSB = 0;
   localparam int CMD_OP_W = 5;
   localparam int CMD_BIT_LSB = 8;
   localparam int CMD_IMM_LSB = 16;
   localparam int CMD_ADDR_LSB = 24;
   // Memory geometry
   localparam int MEM_AW = 8;
   localparam int MEM_DEPTH = 256;
   localparam int PROG_AW = 12;
   localparam int PROG_DEPTH = 4096;
   localparam logic [3:0] LAST_PAGE = 4'hF;
   // Reset values and constants
   localparam logic [7:0] RST_BYTE = 8'h00;
   localparam logic [5:0] RST_FLAGS = 6'h00;
   localparam logic [7:0] BCD_LIMIT = 8'h09;
   localparam logic [7:0] BCD_ADJ_LO = 8'h06;
   localparam logic [7:0] BCD_ADJ_HI = 8'h60;
   localparam logic [1:0] RESP_OKAY = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;
   // Cycle counts
   localparam logic [1:0] CYC_PLAIN = 2'd1;
   localparam logic [1:0] CYC_SKIP = 2'd2;

   typedef enum logic [4:0] {
      OP_SKIP_COPY_IF_ZERO,
      OP_SKIP_IF_BIT_ZERO,
      OP_TABLE_READ_PAGED,
      OP_TABLE_READ_FINAL_PAGE,
      OP_TABLE_READ_PAGED_PREINC,
      OP_TABLE_READ_FINAL_PREINC,
      OP_XOR_TO_ACC,
      OP_XOR_INTO_MEMORY,
      OP_XOR_IMM,
      OP_EXT_ADD_CARRY,
      OP_EXT_ADD_CARRY_TO_MEM,
      OP_EXT_ADD,
      OP_EXT_ADD_TO_MEM,
      OP_EXT_AND,
      OP_EXT_AND_TO_MEM,
      OP_EXT_CLEAR,
      OP_EXT_CLEAR_BIT,
      OP_EXT_COMPLEMENT,
      OP_EXT_COMPLEMENT_TO_ACC,
      OP_EXT_BCD_ADJUST,
      OP_EXT_DECREMENT,
      OP_EXT_DECREMENT_TO_ACC,
      OP_EXT_INCREMENT,
      OP_EXT_INCREMENT_TO_ACC,
      OP_EXT_MOVE_TO_ACC,
      OP_EXT_MOVE_TO_MEM,
      OP_EXT_OR,
      OP_EXT_OR_TO_MEM,
      OP_EXT_ROTATE_LEFT
   } ixs_op_e;

   // Flags: sign_result, signed_wrap, zero, nibble_carry, carry
   typedef struct packed {
      logic sign_result_flag;
      logic signed_wrap_flag;
      logic zero_flag;
      logic nibble_carry_flag;
      logic carry_flag;
   } ixs_flags_s;

   // Decoded command word
   typedef struct packed {
      logic [7:0] mem_addr;
      logic [7:0] imm;
      logic [4:0] pad_hi;
      logic [2:0] bit_sel;
      logic [2:0] pad_lo;
      logic [4:0] op;
   } ixs_cmd_s;
endpackage : ixs_pkg

// ---- src/ixs_exec.sv ----
// Execution datapath for skip, table read, XOR and extended data memory instructions
// How it works
// - Copy byte to accumulator, skip when zero
// - Skip next instruction when selected bit zero
// - Taken skip costs two instruction cycles
// - Paged table read uses high:low pointer
// - Final-page table read uses low pointer only
// - Pre-increment low pointer before table read
// - XOR to accumulator or memory, zero flag
// - Extended forms address any memory byte directly
// - Add with carry updates five flags
// - Add without carry updates five flags
// - AND updates only zero flag
// - OR updates only zero flag
// - Clear byte or bit, no flags
// - Complement to memory or accumulator, zero flag
// - Decimal adjust adds six per nibble
// - Decimal adjust changes only carry flag
// - Decrement to memory or accumulator, zero flag
// - Increment to memory or accumulator, zero flag
// - Move byte either way, no flags
// - Rotate memory byte left, no flags
// - Accumulator-target forms leave memory unchanged
`timescale 1ns/100ps
`default_nettype none
module ixs_exec (
   // Clock and reset
   input wire logic clk_i,
   input wire logic reset_n_i,
   // AXI4-Lite write address
   input wire logic [7:0] s_axi_awaddr_i,
   input wire logic s_axi_awvalid_i,
   output logic s_axi_awready_o,
   // AXI4-Lite write data
   input wire logic [31:0] s_axi_wdata_i,
   input wire logic [3:0] s_axi_wstrb_i,
   input wire logic s_axi_wvalid_i,
   output logic s_axi_wready_o,
   // AXI4-Lite write response
   output logic [1:0] s_axi_bresp_o,
   output logic s_axi_bvalid_o,
   input wire logic s_axi_bready_i,
   // AXI4-Lite read address
   input wire logic [7:0] s_axi_araddr_i,
   input wire logic s_axi_arvalid_i,
   output logic s_axi_arready_o,
   // AXI4-Lite read data
   output logic [31:0] s_axi_rdata_o,
   output logic [1:0] s_axi_rresp_o,
   output logic s_axi_rvalid_o,
   input wire logic s_axi_rready_i,
   // Execution status
   output logic skip_o,
   output logic [1:0] cycles_o
);
   logic [7:0] data_mem [ixs_pkg::MEM_DEPTH];
   logic [15:0] prog_mem [ixs_pkg::PROG_DEPTH];
   logic [7:0] acc_q;
   ixs_pkg::ixs_flags_s flags_q;
   logic [7:0] ptr_lo_q;
   logic [7:0] ptr_hi_q;
   logic [7:0] tbl_latch_q;
   logic [7:0] mem_addr_q;
   logic [11:0] prog_addr_q;
   logic skip_q;
   logic [1:0] cycles_q;
   logic [7:0] exec_count_q;

   // Write and read channel capture
   logic aw_hold_q;
   logic w_hold_q;
   logic [7:0] aw_addr_q;
   logic [31:0] w_data_q;
   logic [3:0] w_strb_q;
   logic bvalid_q;
   logic [1:0] bresp_q;
   logic rvalid_q;
   logic [31:0] rdata_q;
   logic [1:0] rresp_q;

   logic wr_fire;
   logic mapped_wr;
   ixs_pkg::ixs_cmd_s cmd;

   function automatic logic is_zero(input logic [7:0] v);
      return v == ixs_pkg::RST_BYTE;
   endfunction : is_zero

   function automatic logic [7:0] merge_byte(input logic [7:0] old, input logic [31:0] d,
                                             input logic [3:0] s);
      return s[0] ? d[7:0] : old;
   endfunction : merge_byte

   function automatic logic mapped(input logic [7:0] a);
      return a inside {ixs_pkg::ADDR_ACC, ixs_pkg::ADDR_FLAGS, ixs_pkg::ADDR_PTR_LO,
                       ixs_pkg::ADDR_PTR_HI, ixs_pkg::ADDR_LATCH_HI, ixs_pkg::ADDR_CMD,
                       ixs_pkg::ADDR_STATUS, ixs_pkg::ADDR_MEM_ADDR, ixs_pkg::ADDR_MEM_DATA,
                       ixs_pkg::ADDR_PROG_ADDR, ixs_pkg::ADDR_PROG_DATA};
   endfunction : mapped

   assign s_axi_awready_o = !aw_hold_q && !bvalid_q;
   assign s_axi_wready_o = !w_hold_q && !bvalid_q;
   assign s_axi_arready_o = !rvalid_q;
   assign s_axi_bvalid_o = bvalid_q;
   assign s_axi_bresp_o = bresp_q;
   assign s_axi_rvalid_o = rvalid_q;
   assign s_axi_rdata_o = rdata_q;
   assign s_axi_rresp_o = rresp_q;
   assign skip_o = skip_q;
   assign cycles_o = cycles_q;

   assign wr_fire = aw_hold_q && w_hold_q && !bvalid_q;
   assign mapped_wr = mapped(aw_addr_q);
   assign cmd = ixs_pkg::ixs_cmd_s'(w_data_q);

   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         aw_hold_q <= 1'b0;
         aw_addr_q <= 8'h00;
      end else if (s_axi_awvalid_i && s_axi_awready_o) begin
         aw_hold_q <= 1'b1;
         aw_addr_q <= s_axi_awaddr_i;
      end else if (wr_fire) begin
         aw_hold_q <= 1'b0;
      end
   end

   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         w_hold_q <= 1'b0;
         w_data_q <= 32'h0000_0000;
         w_strb_q <= 4'h0;
      end else if (s_axi_wvalid_i && s_axi_wready_o) begin
         w_hold_q <= 1'b1;
         w_data_q <= s_axi_wdata_i;
         w_strb_q <= s_axi_wstrb_i;
      end else if (wr_fire) begin
         w_hold_q <= 1'b0;
      end
   end

   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         bvalid_q <= 1'b0;
         bresp_q <= ixs_pkg::RESP_OKAY;
      end else if (wr_fire) begin
         bvalid_q <= 1'b1;
         bresp_q <= mapped_wr ? ixs_pkg::RESP_OKAY : ixs_pkg::RESP_SLVERR;
      end else if (s_axi_bready_i) begin
         bvalid_q <= 1'b0;
      end
   end

   // Instruction execution: one command write runs one instruction
   logic [7:0] m;
   logic [8:0] sum;
   logic [4:0] half;
   logic [7:0] res;
   logic [7:0] bcd;
   logic bcd_c;
   logic exec;
   assign exec = wr_fire && (aw_addr_q == ixs_pkg::ADDR_CMD) && w_strb_q[0];
   assign m = data_mem[cmd.mem_addr];
   logic [7:0] tbl_lo;
   logic [11:0] tbl_addr;
   logic [15:0] tbl_word;
   assign tbl_lo = (cmd.op == 5'(ixs_pkg::OP_TABLE_READ_PAGED_PREINC)
      || cmd.op == 5'(ixs_pkg::OP_TABLE_READ_FINAL_PREINC)) ? ptr_lo_q + 8'h01 : ptr_lo_q;
   assign tbl_addr = (cmd.op == 5'(ixs_pkg::OP_TABLE_READ_FINAL_PAGE)
      || cmd.op == 5'(ixs_pkg::OP_TABLE_READ_FINAL_PREINC))
      ? {ixs_pkg::LAST_PAGE, tbl_lo} : {ptr_hi_q[3:0], tbl_lo};
   assign tbl_word = prog_mem[tbl_addr];

   always_comb begin
      logic cin;
      cin = 1'b0;
      if (cmd.op == 5'(ixs_pkg::OP_EXT_ADD_CARRY) || cmd.op == 5'(ixs_pkg::OP_EXT_ADD_CARRY_TO_MEM))
         cin = flags_q.carry_flag;
      sum = {1'b0, acc_q} + {1'b0, m} + {8'h00, cin};
      half = {1'b0, acc_q[3:0]} + {1'b0, m[3:0]} + {4'h0, cin};
      res = sum[7:0];
      bcd = acc_q;
      bcd_c = flags_q.carry_flag;
      if (acc_q[3:0] > ixs_pkg::BCD_LIMIT[3:0] || flags_q.nibble_carry_flag)
         bcd = bcd + ixs_pkg::BCD_ADJ_LO;
      if (acc_q[7:4] > ixs_pkg::BCD_LIMIT[3:0] || flags_q.carry_flag) begin
         bcd = bcd + ixs_pkg::BCD_ADJ_HI;
         bcd_c = 1'b1;
      end
   end

   always_ff @(posedge clk_i) begin
      if (exec) begin
         unique case (ixs_pkg::ixs_op_e'(cmd.op))
            ixs_pkg::OP_XOR_INTO_MEMORY: data_mem[cmd.mem_addr] <= acc_q ^ m;
            ixs_pkg::OP_EXT_ADD_CARRY_TO_MEM, ixs_pkg::OP_EXT_ADD_TO_MEM: data_mem[cmd.mem_addr] <= res;
            ixs_pkg::OP_EXT_AND_TO_MEM: data_mem[cmd.mem_addr] <= acc_q & m;
            ixs_pkg::OP_EXT_OR_TO_MEM: data_mem[cmd.mem_addr] <= acc_q | m;
            ixs_pkg::OP_EXT_CLEAR: data_mem[cmd.mem_addr] <= ixs_pkg::RST_BYTE;
            ixs_pkg::OP_EXT_CLEAR_BIT: begin
               data_mem[cmd.mem_addr] <= m & ~(8'h01 << cmd.bit_sel);
            end
            ixs_pkg::OP_EXT_COMPLEMENT: data_mem[cmd.mem_addr] <= ~m;
            ixs_pkg::OP_EXT_BCD_ADJUST: data_mem[cmd.mem_addr] <= bcd;
            ixs_pkg::OP_EXT_DECREMENT: data_mem[cmd.mem_addr] <= m - 8'h01;
            ixs_pkg::OP_EXT_INCREMENT: data_mem[cmd.mem_addr] <= m + 8'h01;
            ixs_pkg::OP_EXT_MOVE_TO_MEM: data_mem[cmd.mem_addr] <= acc_q;
            ixs_pkg::OP_EXT_ROTATE_LEFT: data_mem[cmd.mem_addr] <= {m[6:0], m[7]};
            ixs_pkg::OP_TABLE_READ_PAGED, ixs_pkg::OP_TABLE_READ_FINAL_PAGE, ixs_pkg::OP_TABLE_READ_PAGED_PREINC,
            ixs_pkg::OP_TABLE_READ_FINAL_PREINC: data_mem[cmd.mem_addr] <= tbl_word[7:0];
            default: ; // Accumulator-target forms leave memory alone
         endcase
      end else if (wr_fire && aw_addr_q == ixs_pkg::ADDR_MEM_DATA && w_strb_q[0]) begin
         data_mem[mem_addr_q] <= w_data_q[7:0];
      end
   end

   always_ff @(posedge clk_i) begin
      if (wr_fire && aw_addr_q == ixs_pkg::ADDR_PROG_DATA && w_strb_q[1:0] == 2'b11) begin
         prog_mem[prog_addr_q] <= w_data_q[15:0];
      end
   end

   // Accumulator, flags, table latch and skip outcome
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         acc_q <= ixs_pkg::RST_BYTE;
         flags_q <= ixs_pkg::ixs_flags_s'(ixs_pkg::RST_FLAGS[4:0]);
         ptr_lo_q <= ixs_pkg::RST_BYTE;
         ptr_hi_q <= ixs_pkg::RST_BYTE;
         tbl_latch_q <= ixs_pkg::RST_BYTE;
         skip_q <= 1'b0;
         cycles_q <= ixs_pkg::CYC_PLAIN;
      end else if (exec) begin
         skip_q <= 1'b0;
         cycles_q <= ixs_pkg::CYC_PLAIN;
         unique case (ixs_pkg::ixs_op_e'(cmd.op))
            ixs_pkg::OP_SKIP_COPY_IF_ZERO: begin
               acc_q <= m;
               skip_q <= is_zero(m);
               cycles_q <= is_zero(m) ? ixs_pkg::CYC_SKIP : ixs_pkg::CYC_PLAIN;
            end
            ixs_pkg::OP_SKIP_IF_BIT_ZERO: begin
               skip_q <= !m[cmd.bit_sel];
               cycles_q <= !m[cmd.bit_sel] ? ixs_pkg::CYC_SKIP : ixs_pkg::CYC_PLAIN;
            end
            ixs_pkg::OP_TABLE_READ_PAGED, ixs_pkg::OP_TABLE_READ_FINAL_PAGE:
               tbl_latch_q <= tbl_word[15:8];
            ixs_pkg::OP_TABLE_READ_PAGED_PREINC, ixs_pkg::OP_TABLE_READ_FINAL_PREINC: begin
               ptr_lo_q <= tbl_lo;
               tbl_latch_q <= tbl_word[15:8];
            end
            ixs_pkg::OP_XOR_TO_ACC: begin
               acc_q <= acc_q ^ m;
               flags_q.zero_flag <= is_zero(acc_q ^ m);
            end
            ixs_pkg::OP_XOR_INTO_MEMORY: flags_q.zero_flag <= is_zero(acc_q ^ m);
            ixs_pkg::OP_XOR_IMM: begin
               acc_q <= acc_q ^ cmd.imm;
               flags_q.zero_flag <= is_zero(acc_q ^ cmd.imm);
            end
            ixs_pkg::OP_EXT_ADD_CARRY, ixs_pkg::OP_EXT_ADD_CARRY_TO_MEM,
            ixs_pkg::OP_EXT_ADD, ixs_pkg::OP_EXT_ADD_TO_MEM: begin
               if (cmd.op == 5'(ixs_pkg::OP_EXT_ADD_CARRY) || cmd.op == 5'(ixs_pkg::OP_EXT_ADD))
                  acc_q <= res;
               flags_q.carry_flag <= sum[8];
               flags_q.nibble_carry_flag <= half[4];
               flags_q.zero_flag <= is_zero(res);
               flags_q.signed_wrap_flag <= (acc_q[7] == m[7]) && (res[7] != acc_q[7]);
               flags_q.sign_result_flag <= res[7] ^ ((acc_q[7] == m[7]) && (res[7] != acc_q[7]));
            end
            ixs_pkg::OP_EXT_AND, ixs_pkg::OP_EXT_AND_TO_MEM: begin
               if (cmd.op == 5'(ixs_pkg::OP_EXT_AND))
                  acc_q <= acc_q & m;
               flags_q.zero_flag <= is_zero(acc_q & m);
            end
            ixs_pkg::OP_EXT_OR, ixs_pkg::OP_EXT_OR_TO_MEM: begin
               if (cmd.op == 5'(ixs_pkg::OP_EXT_OR))
                  acc_q <= acc_q | m;
               flags_q.zero_flag <= is_zero(acc_q | m);
            end
            ixs_pkg::OP_EXT_COMPLEMENT, ixs_pkg::OP_EXT_COMPLEMENT_TO_ACC: begin
               if (cmd.op == 5'(ixs_pkg::OP_EXT_COMPLEMENT_TO_ACC))
                  acc_q <= ~m;
               flags_q.zero_flag <= is_zero(~m);
            end
            ixs_pkg::OP_EXT_BCD_ADJUST: flags_q.carry_flag <= bcd_c;
            ixs_pkg::OP_EXT_DECREMENT, ixs_pkg::OP_EXT_DECREMENT_TO_ACC: begin
               if (cmd.op == 5'(ixs_pkg::OP_EXT_DECREMENT_TO_ACC))
                  acc_q <= m - 8'h01;
               flags_q.zero_flag <= is_zero(m - 8'h01);
            end
            ixs_pkg::OP_EXT_INCREMENT, ixs_pkg::OP_EXT_INCREMENT_TO_ACC: begin
               if (cmd.op == 5'(ixs_pkg::OP_EXT_INCREMENT_TO_ACC))
                  acc_q <= m + 8'h01;
               flags_q.zero_flag <= is_zero(m + 8'h01);
            end
            ixs_pkg::OP_EXT_MOVE_TO_ACC: acc_q <= m;
            default: ;
         endcase
      end else if (wr_fire && w_strb_q[0]) begin
         unique case (aw_addr_q)
            ixs_pkg::ADDR_ACC: acc_q <= w_data_q[7:0];
            ixs_pkg::ADDR_FLAGS: flags_q <= ixs_pkg::ixs_flags_s'(w_data_q[4:0]);
            ixs_pkg::ADDR_PTR_LO: ptr_lo_q <= w_data_q[7:0];
            ixs_pkg::ADDR_PTR_HI: ptr_hi_q <= w_data_q[7:0];
            ixs_pkg::ADDR_LATCH_HI: tbl_latch_q <= w_data_q[7:0];
            default: ;
         endcase
      end
   end

   // Host-side address pointers and executed-instruction count
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         mem_addr_q <= ixs_pkg::RST_BYTE;
         prog_addr_q <= 12'h000;
         exec_count_q <= ixs_pkg::RST_BYTE;
      end else begin
         if (exec)
            exec_count_q <= exec_count_q + 8'h01;
         if (wr_fire && aw_addr_q == ixs_pkg::ADDR_MEM_ADDR)
            mem_addr_q <= merge_byte(mem_addr_q, w_data_q, w_strb_q);
         if (wr_fire && aw_addr_q == ixs_pkg::ADDR_PROG_ADDR && w_strb_q[1:0] == 2'b11)
            prog_addr_q <= w_data_q[11:0];
      end
   end

   // Read channel
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         rvalid_q <= 1'b0;
         rdata_q <= 32'h0000_0000;
         rresp_q <= ixs_pkg::RESP_OKAY;
      end else if (s_axi_arvalid_i && s_axi_arready_o) begin
         rvalid_q <= 1'b1;
         rresp_q <= mapped(s_axi_araddr_i) ? ixs_pkg::RESP_OKAY : ixs_pkg::RESP_SLVERR;
         unique case (s_axi_araddr_i)
            ixs_pkg::ADDR_ACC: rdata_q <= {24'h00_0000, acc_q};
            ixs_pkg::ADDR_FLAGS: rdata_q <= {27'h000_0000, flags_q};
            ixs_pkg::ADDR_PTR_LO: rdata_q <= {24'h00_0000, ptr_lo_q};
            ixs_pkg::ADDR_PTR_HI: rdata_q <= {24'h00_0000, ptr_hi_q};
            ixs_pkg::ADDR_LATCH_HI: rdata_q <= {24'h00_0000, tbl_latch_q};
            ixs_pkg::ADDR_STATUS: rdata_q <= {21'h00_0000, exec_count_q, cycles_q, skip_q};
            ixs_pkg::ADDR_MEM_ADDR: rdata_q <= {24'h00_0000, mem_addr_q};
            ixs_pkg::ADDR_MEM_DATA: rdata_q <= {24'h00_0000, data_mem[mem_addr_q]};
            ixs_pkg::ADDR_PROG_ADDR: rdata_q <= {20'h0_0000, prog_addr_q};
            ixs_pkg::ADDR_PROG_DATA: rdata_q <= {16'h0000, prog_mem[prog_addr_q]};
            default: rdata_q <= 32'h0000_0000;
         endcase
      end else if (s_axi_rready_i) begin
         rvalid_q <= 1'b0;
      end
   end
endmodule : ixs_exec
`default_nettype wire

// ---- sim/ixs_exec_sva.sv ----
// Port-level checks for the execution block
`timescale 1ns/100ps
`default_nettype none
module ixs_exec_sva (
   // Clock and reset
   input wire logic clk_i,
   input wire logic reset_n_i,
   // Register bus
   input wire logic [7:0] s_axi_awaddr_i,
   input wire logic s_axi_awvalid_i,
   input wire logic s_axi_awready_o,
   input wire logic [31:0] s_axi_wdata_i,
   input wire logic [3:0] s_axi_wstrb_i,
   input wire logic s_axi_wvalid_i,
   input wire logic s_axi_wready_o,
   input wire logic [1:0] s_axi_bresp_o,
   input wire logic s_axi_bvalid_o,
   input wire logic s_axi_bready_i,
   input wire logic [7:0] s_axi_araddr_i,
   input wire logic s_axi_arvalid_i,
   input wire logic s_axi_arready_o,
   input wire logic [31:0] s_axi_rdata_o,
   input wire logic [1:0] s_axi_rresp_o,
   input wire logic s_axi_rvalid_o,
   input wire logic s_axi_rready_i,
   // Status
   input wire logic skip_o,
   input wire logic [1:0] cycles_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!reset_n_i);
   chk_skip_two_cyc: assert property (skip_o |-> cycles_o == ixs_pkg::CYC_SKIP)
      else $error("skip without two cycles");
   chk_plain_one_cyc: assert property (!skip_o |-> cycles_o == ixs_pkg::CYC_PLAIN)
      else $error("plain step not one cycle");
   chk_status_on_exec: assert property (!$stable({skip_o, cycles_o}) |-> $rose(s_axi_bvalid_o))
      else $error("status moved without a write");
   chk_bresp_hold: assert property (s_axi_bvalid_o && !s_axi_bready_i |=> s_axi_bvalid_o && $stable(s_axi_bresp_o))
      else $error("write response dropped");
   chk_rdata_hold: assert property (s_axi_rvalid_o && !s_axi_rready_i |=> s_axi_rvalid_o && $stable(s_axi_rdata_o))
      else $error("read data dropped");
   chk_read_answer: assert property (s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o)
      else $error("read answer late");
   chk_write_answer: assert property (s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i && s_axi_wready_o
      |=> ##1 s_axi_bvalid_o) else $error("write answer late");
   chk_ar_blocked: assert property (s_axi_rvalid_o |-> !s_axi_arready_o)
      else $error("address taken while read pending");
   chk_b_release: assert property (s_axi_bvalid_o && s_axi_bready_i ##1 1'b1 |-> !s_axi_bvalid_o)
      else $error("response not released");
   cov_skip: cover property ($rose(skip_o));
   cov_read: cover property (s_axi_rvalid_o && s_axi_rready_i);
   cov_write: cover property (s_axi_bvalid_o && s_axi_bready_i);
endmodule : ixs_exec_sva
`default_nettype wire

// ---- sim/tb_top.sv ----
// Self-checking bench for the execution block
`timescale 1ns/100ps
`default_nettype none
module tb_top;
   // Opcode masks: to accumulator, no flag change, add forms, carry-in forms
   localparam logic [31:0] ACC_M = 32'h05A4_2B40;
   localparam logic [31:0] NOF_M = 32'h1301_8000;
   localparam logic [31:0] ADD_M = 32'h0000_1E00;
   localparam logic [31:0] CIN_M = 32'h0000_0600;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic [7:0] awaddr = 8'h00;
   logic [7:0] araddr = 8'h00;
   logic [31:0] wdata = 32'h0000_0000;
   logic [3:0] wstrb = 4'hF;
   logic awvalid = 1'b0;
   logic wvalid = 1'b0;
   logic bready = 1'b0;
   logic arvalid = 1'b0;
   logic rready = 1'b0;
   logic awready, wready, bvalid, arready, rvalid, skip;
   logic [1:0] bresp, rresp, cycles, br;
   logic [31:0] rdata;
   int n_mismatch = 0;
   int compares = 0;
   always #5 clk = ~clk;
   ixs_exec u_dut (.clk_i(clk), .reset_n_i(rst_n), .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid),
      .s_axi_awready_o(awready), .s_axi_wdata_i(wdata), .s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid),
      .s_axi_wready_o(wready), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
      .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready), .s_axi_rdata_o(rdata),
      .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready), .skip_o(skip), .cycles_o(cycles));
   task automatic results;
      if (n_mismatch == 0 && compares > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : results
   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         n_mismatch++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : cmp
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic ta, tw, tb;
      @(posedge clk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      tb = 1'b0;
      for (int n = 0; n < 40 && !tb; n++) begin
         @(negedge clk);
         ta = awvalid && awready;
         tw = wvalid && wready;
         tb = bvalid;
         br = bresp;
         @(posedge clk);
         if (ta) awvalid <= 1'b0;
         if (tw) wvalid <= 1'b0;
      end
      bready <= 1'b0;
      if (!tb) n_mismatch++;
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      logic ta, tb;
      @(posedge clk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      tb = 1'b0;
      for (int n = 0; n < 40 && !tb; n++) begin
         @(negedge clk);
         ta = arvalid && arready;
         tb = rvalid;
         d = rdata;
         r = rresp;
         @(posedge clk);
         if (ta) arvalid <= 1'b0;
      end
      rready <= 1'b0;
      if (!tb) n_mismatch++;
   endtask : rd
   task automatic chk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
      logic [31:0] d;
      logic [1:0] r;
      rd(a, d, r);
      cmp(d & m, e);
   endtask : chk
   task automatic ex(input logic [4:0] op, input logic [2:0] b, input logic [7:0] imm, input logic [7:0] a);
      wr(ixs_pkg::ADDR_CMD, {a, imm, 5'h00, b, 3'h0, op});
   endtask : ex
   task automatic st(input logic [7:0] acc, input logic [4:0] f, input logic [7:0] ma, input logic [7:0] md);
      wr(ixs_pkg::ADDR_ACC, {24'h0, acc});
      wr(ixs_pkg::ADDR_FLAGS, {27'h0, f});
      wr(ixs_pkg::ADDR_MEM_ADDR, {24'h0, ma});
      wr(ixs_pkg::ADDR_MEM_DATA, {24'h0, md});
   endtask : st
   task automatic t_bus;
      logic [31:0] d;
      logic [1:0] r;
      rd(8'h3C, d, r);
      cmp({30'h0, r}, {30'h0, ixs_pkg::RESP_SLVERR});
      cmp(d, 32'h0000_0000);
      wr(8'h3C, 32'h0000_0011);
      cmp({30'h0, br}, {30'h0, ixs_pkg::RESP_SLVERR});
      chk(ixs_pkg::ADDR_ACC, 32'hFFFF_FFFF, 32'h0000_0000);
      wstrb <= 4'hE;
      wr(ixs_pkg::ADDR_ACC, 32'h0000_0042);
      wstrb <= 4'hF;
      chk(ixs_pkg::ADDR_ACC, 32'hFFFF_FFFF, 32'h0000_0000);
   endtask : t_bus
   // Status low bits are cycles then skip; flags must stay as loaded
   task automatic sk(input logic [4:0] op, input logic [2:0] b, input logic [7:0] m, input logic [7:0] e,
      input logic [2:0] s);
      st(8'h5A, 5'h1F, 8'hF3, m);
      ex(op, b, 8'h00, 8'hF3);
      chk(ixs_pkg::ADDR_ACC, 32'h0000_00FF, {24'h0, e});
      chk(ixs_pkg::ADDR_STATUS, 32'h0000_0007, {29'h0, s});
      cmp({29'h0, skip, cycles}, {29'h0, s[0], s[2:1]});
      chk(ixs_pkg::ADDR_FLAGS, 32'h0000_001F, 32'h0000_001F);
   endtask : sk
   task automatic t_skip;
      sk(ixs_pkg::OP_SKIP_COPY_IF_ZERO, 3'h0, 8'h00, 8'h00, 3'h5);
      sk(ixs_pkg::OP_SKIP_COPY_IF_ZERO, 3'h0, 8'h81, 8'h81, 3'h2);
      sk(ixs_pkg::OP_SKIP_IF_BIT_ZERO, 3'h3, 8'hF7, 8'h5A, 3'h5);
      sk(ixs_pkg::OP_SKIP_IF_BIT_ZERO, 3'h4, 8'hF7, 8'h5A, 3'h2);
   endtask : t_skip
   task automatic tbl(input logic [4:0] op, input logic [7:0] lo, input logic [7:0] ma, input logic [15:0] w,
      input logic [7:0] lo_e);
      wr(ixs_pkg::ADDR_PTR_LO, {24'h0, lo});
      ex(op, 3'h0, 8'h00, ma);
      wr(ixs_pkg::ADDR_MEM_ADDR, {24'h0, ma});
      chk(ixs_pkg::ADDR_MEM_DATA, 32'h0000_00FF, {24'h0, w[7:0]});
      chk(ixs_pkg::ADDR_LATCH_HI, 32'h0000_00FF, {24'h0, w[15:8]});
      chk(ixs_pkg::ADDR_PTR_LO, 32'h0000_00FF, {24'h0, lo_e});
   endtask : tbl
   task automatic t_table;
      wr(ixs_pkg::ADDR_PROG_ADDR, 32'h0000_03A5);
      wr(ixs_pkg::ADDR_PROG_DATA, 32'h0000_BEEF);
      wr(ixs_pkg::ADDR_PROG_ADDR, 32'h0000_0FA5);
      wr(ixs_pkg::ADDR_PROG_DATA, 32'h0000_1234);
      wr(ixs_pkg::ADDR_PROG_ADDR, 32'h0000_0300);
      wr(ixs_pkg::ADDR_PROG_DATA, 32'h0000_5678);
      wr(ixs_pkg::ADDR_PTR_HI, 32'h0000_0003);
      wr(ixs_pkg::ADDR_FLAGS, 32'h0000_0015);
      tbl(ixs_pkg::OP_TABLE_READ_PAGED, 8'hA5, 8'h10, 16'hBEEF, 8'hA5);
      tbl(ixs_pkg::OP_TABLE_READ_FINAL_PAGE, 8'hA5, 8'hC1, 16'h1234, 8'hA5);
      tbl(ixs_pkg::OP_TABLE_READ_PAGED_PREINC, 8'hA4, 8'h12, 16'hBEEF, 8'hA5);
      tbl(ixs_pkg::OP_TABLE_READ_FINAL_PREINC, 8'hA4, 8'h13, 16'h1234, 8'hA5);
      tbl(ixs_pkg::OP_TABLE_READ_PAGED_PREINC, 8'hFF, 8'hF4, 16'h5678, 8'h00);
      chk(ixs_pkg::ADDR_FLAGS, 32'h0000_001F, 32'h0000_0015);
   endtask : t_table
   // Opcodes 6 to 28 on two operand sets; the second gives zero and signed wrap results
   task automatic t_alu;
      logic [7:0] a, m, r, ma;
      logic [4:0] f, nf;
      logic [8:0] s;
      logic h, v, cin;
      for (int op = 6; op < 29; op++) begin
         for (int p = 0; p < 2; p++) begin
            a = p ? 8'h80 : 8'h3C;
            m = p ? 8'h80 : 8'hC5;
            f = p ? 5'h00 : 5'h01;
            ma = p ? 8'hE9 : 8'h07;
            cin = f[0] & CIN_M[op];
            s = a + m + cin;
            h = ({1'b0, a[3:0]} + m[3:0] + cin) > 5'h0F;
            v = (a[7] == m[7]) && (s[7] != a[7]);
            case (op)
               6, 7: r = a ^ m;
               8: r = a ^ 8'hA5;
               9, 10, 11, 12: r = s[7:0];
               13, 14: r = a & m;
               15: r = 8'h00;
               16: r = m & 8'hF7;
               17, 18: r = ~m;
               19: r = a + ((a[3:0] > 4'h9 || f[1]) ? 8'h06 : 8'h00) + ((a[7:4] > 4'h9 || f[0]) ? 8'h60 : 8'h00);
               20, 21: r = m - 8'h01;
               22, 23: r = m + 8'h01;
               24: r = m;
               25: r = a;
               26, 27: r = a | m;
               default: r = {m[6:0], m[7]};
            endcase
            nf = f;
            if (ADD_M[op]) nf = {s[7] ^ v, v, s[7:0] == 8'h00, h, s[8]};
            else if (op == 19) nf[0] = f[0] | (a[7:4] > 4'h9);
            else if (!NOF_M[op]) nf[2] = (r == 8'h00);
            st(a, f, ma, m);
            ex(5'(op), 3'h3, 8'hA5, ma);
            chk(ixs_pkg::ADDR_ACC, 32'h0000_00FF, {24'h0, ACC_M[op] ? r : a});
            chk(ixs_pkg::ADDR_MEM_DATA, 32'h0000_00FF, {24'h0, ACC_M[op] ? m : r});
            chk(ixs_pkg::ADDR_FLAGS, 32'h0000_001F, {27'h0, nf});
            cmp({29'h0, skip, cycles}, 32'h0000_0001);
         end
      end
   endtask : t_alu
   initial begin
      repeat (4) @(posedge clk);
      rst_n <= 1'b1;
      t_bus;
      t_skip;
      t_table;
      t_alu;
      results;
   end
   initial begin
      #400_000;
      n_mismatch++;
      results;
   end
endmodule : tb_top
bind ixs_exec ixs_exec_sva u_sva (.clk_i, .reset_n_i, .s_axi_awaddr_i, .s_axi_awvalid_i, .s_axi_awready_o,
   .s_axi_wdata_i, .s_axi_wstrb_i, .s_axi_wvalid_i, .s_axi_wready_o, .s_axi_bresp_o, .s_axi_bvalid_o,
   .s_axi_bready_i, .s_axi_araddr_i, .s_axi_arvalid_i, .s_axi_arready_o, .s_axi_rdata_o, .s_axi_rresp_o,
   .s_axi_rvalid_o, .s_axi_rready_i, .skip_o, .cycles_o);
`default_nettype wire
